// ---- pkg/prtpc_map.svh ----
// register map, field positions, reset values and codes for the reset and test-pattern block
`ifndef PRTPC_MAP_SVH
`define PRTPC_MAP_SVH

`define PRTPC_ADDR_W 5
`define PRTPC_OFF_RESET_CTRL 5'h1F
`define PRTPC_OFF_TEST_CTRL 5'h05
`define PRTPC_IDX_TEST_CTRL 6'h25
`define PRTPC_RST_RESET_CTRL 16'h0000
`define PRTPC_RST_TEST_CTRL 16'h0480

`define PRTPC_BIT_FULL_RESET 15
`define PRTPC_BIT_SOFT_RESTART 14
`define PRTPC_RESET_CTRL_RW_MASK 16'h3FFF
`define PRTPC_TEST_CTRL_RW_MASK 16'h0FFF

`define PRTPC_PULSE_HI 11
`define PRTPC_PULSE_LO 10
`define PRTPC_BIT_ZCNT_MSB 9
`define PRTPC_BIT_EXT_EN 8
`define PRTPC_BIT_ALL_PAIRS 7
`define PRTPC_PAIR_HI 6
`define PRTPC_PAIR_LO 5
`define PRTPC_BIT_TEN_EN 4
`define PRTPC_CODE_HI 3
`define PRTPC_CODE_LO 0

`define PRTPC_PULSE_P2 2'h0
`define PRTPC_PULSE_M2 2'h1
`define PRTPC_PULSE_P1 2'h2
`define PRTPC_PULSE_M1 2'h3
`define PRTPC_LVL_P2 3'h2
`define PRTPC_LVL_M2 3'h6
`define PRTPC_LVL_P1 3'h1
`define PRTPC_LVL_M1 3'h7

`define PRTPC_PAIR_ALL 4'hF
`define PRTPC_PAIR_NONE 4'h0
`define PRTPC_ZCNT_NONE 5'h00

`define PRTPC_RESET_CYCLES 8'h10
`define PRTPC_RESTART_CYCLES 8'h08
`define PRTPC_STRAP_W 16

`endif

// ---- pkg/prtpc_pkg.sv ----
// types shared by the reset and test-pattern control block
package prtpc_pkg;

  // ten-megabit pattern codes
  typedef enum logic [3:0] {
    PRTPC_TP_NLP = 4'h0,
    PRTPC_TP_PULSE_ONE = 4'h1,
    PRTPC_TP_PULSE_ZERO = 4'h2,
    PRTPC_TP_REP_ONE = 4'h3,
    PRTPC_TP_REP_ZERO = 4'h4,
    PRTPC_TP_PREAMBLE = 4'h5,
    PRTPC_TP_ONE_IDLE = 4'h6,
    PRTPC_TP_ZERO_IDLE = 4'h7,
    PRTPC_TP_REP_1001 = 4'h8,
    PRTPC_TP_RANDOM = 4'h9,
    PRTPC_TP_IDLE_00 = 4'hA,
    PRTPC_TP_IDLE_01 = 4'hB,
    PRTPC_TP_IDLE_10 = 4'hC,
    PRTPC_TP_IDLE_11 = 4'hD,
    PRTPC_TP_RSVD_E = 4'hE,
    PRTPC_TP_RSVD_F = 4'hF
  } prtpc_ten_code_t;

  // decoded test configuration handed to the line drivers
  typedef struct packed {
    logic [2:0] pulse_level;
    logic [3:0] pair_enable;
    logic ext_fast_active;
    logic [4:0] zero_count;
    logic ten_active;
    prtpc_ten_code_t ten_code;
  } prtpc_test_cfg_t;

  // register bus request
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } prtpc_bus_req_t;

  // reset sequencer states
  typedef enum logic [2:0] {
    PRTPC_SEQ_IDLE = 3'b001,
    PRTPC_SEQ_RESET = 3'b010,
    PRTPC_SEQ_RESTART = 3'b100
  } prtpc_seq_state_t;

endpackage

// ---- hw/prtpc_strap_sync.sv ----
// three-stage synchroniser for strap inputs, change taken when stages two and three agree
module prtpc_strap_sync #(
  parameter int WIDTH = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  // sampling chain
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept bits where the last two stages agree
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      out_q <= '0;
    end else begin
      out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    end
  end

  assign sync_o = out_q;

endmodule

// ---- hw/prtpc_pattern_decode.sv ----
// decodes the test-pattern register into line-driver controls
`include "prtpc_map.svh"
module prtpc_pattern_decode (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] test_ctrl_i,
  output prtpc_pkg::prtpc_test_cfg_t cfg_o
);

  prtpc_pkg::prtpc_test_cfg_t cfg_d;
  prtpc_pkg::prtpc_test_cfg_t cfg_q;
  logic [1:0] pulse_sel;
  logic [1:0] pair_sel;

  // field decode
  always_comb begin
    pulse_sel = test_ctrl_i[`PRTPC_PULSE_HI:`PRTPC_PULSE_LO];
    pair_sel = test_ctrl_i[`PRTPC_PAIR_HI:`PRTPC_PAIR_LO];
    cfg_d = '0;
    case (pulse_sel)
      `PRTPC_PULSE_P2: cfg_d.pulse_level = `PRTPC_LVL_P2;
      `PRTPC_PULSE_M2: cfg_d.pulse_level = `PRTPC_LVL_M2;
      `PRTPC_PULSE_P1: cfg_d.pulse_level = `PRTPC_LVL_P1;
      default: cfg_d.pulse_level = `PRTPC_LVL_M1;
    endcase
    if (test_ctrl_i[`PRTPC_BIT_ALL_PAIRS]) begin
      cfg_d.pair_enable = `PRTPC_PAIR_ALL;
    end else begin
      cfg_d.pair_enable = 4'(4'h1 << pair_sel);
    end
    cfg_d.zero_count = {test_ctrl_i[`PRTPC_BIT_ZCNT_MSB], test_ctrl_i[`PRTPC_CODE_HI:`PRTPC_CODE_LO]};
    cfg_d.ext_fast_active = test_ctrl_i[`PRTPC_BIT_EXT_EN] & ~test_ctrl_i[`PRTPC_BIT_TEN_EN];
    cfg_d.ten_active = test_ctrl_i[`PRTPC_BIT_TEN_EN];
    cfg_d.ten_code = prtpc_pkg::prtpc_ten_code_t'(test_ctrl_i[`PRTPC_CODE_HI:`PRTPC_CODE_LO]);
  end

  // registered so the line drivers see glitch-free controls
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg_o = cfg_q;

endmodule

// ---- hw/prtpc_ctrl.sv ----
// reset/restart control and line test-pattern register bank with pattern engine
`include "prtpc_map.svh"
//
// Function
// - writing one to full reset resets transceiver, restores register defaults, self-clears
// - full reset reloads strap-backed defaults from most recently latched strap values; code re-samples the synchronised strap pins while the reset runs
// - writing one to soft restart restarts operation, keeps registers, self-clears
// - two-bit field selects pattern seven pulse level: +2, -2, +1, -1
// - extended fast pattern is one then N zeros, N from bit 9 and 3:0
// - zero count of zero clears the pattern shift register instead of running
// - extended-pattern enable runs fast pattern; software keeps ten-megabit enable low
// - channel-select top bit set drives the pattern onto all four pairs
// - top bit clear, lower two bits pick pair A, B, C or D
// - bit 4 enables ten-megabit test-pattern generation
// - four-bit code selects the ten-megabit pattern among fourteen defined kinds
module prtpc_ctrl #(
  parameter int RESET_CYCLES = `PRTPC_RESET_CYCLES,
  parameter int RESTART_CYCLES = `PRTPC_RESTART_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [15:0] strap_i,
  output logic [15:0] strap_default_o,
  output logic core_reset_n_o,
  output logic restart_o,
  output prtpc_pkg::prtpc_test_cfg_t test_cfg_o,
  output logic fast_pattern_o,
  output logic [4:0] fast_shift_o
);

  prtpc_pkg::prtpc_bus_req_t req;
  prtpc_pkg::prtpc_seq_state_t state_q;
  logic [7:0] seq_cnt_q;
  logic [15:0] reset_ctrl_q;
  logic [15:0] test_ctrl_q;
  logic [15:0] strap_sync;
  logic [15:0] strap_latch_q;
  logic [15:0] rdata_q;
  logic [4:0] shift_q;
  logic [4:0] zcnt_q;
  logic wr_reset_ctrl;
  logic wr_test_ctrl;
  logic full_req;
  logic restart_req;
  logic seq_done;
  logic full_busy;
  logic restart_busy;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign wr_reset_ctrl = req.wr && (req.addr == `PRTPC_OFF_RESET_CTRL);
  assign wr_test_ctrl = req.wr && (req.addr == `PRTPC_OFF_TEST_CTRL);
  assign full_req = wr_reset_ctrl && req.wdata[`PRTPC_BIT_FULL_RESET];
  assign restart_req = wr_reset_ctrl && req.wdata[`PRTPC_BIT_SOFT_RESTART] && !full_req;
  assign seq_done = (seq_cnt_q == 8'h00);
  assign full_busy = (state_q == prtpc_pkg::PRTPC_SEQ_RESET);
  assign restart_busy = (state_q == prtpc_pkg::PRTPC_SEQ_RESTART);

  // strap pins come from outside the clock domain
  prtpc_strap_sync #(
    .WIDTH(`PRTPC_STRAP_W)
  ) u_strap_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(strap_i),
    .sync_o(strap_sync)
  );

  // strap latch cleared by reset and taken only while a full reset runs
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      strap_latch_q <= '0;
    end else if (full_busy) begin
      strap_latch_q <= strap_sync;
    end
  end

  // reset / restart sequencer; a full reset overrides a restart
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q <= prtpc_pkg::PRTPC_SEQ_IDLE;
      seq_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        prtpc_pkg::PRTPC_SEQ_IDLE: begin
          if (full_req) begin
            state_q <= prtpc_pkg::PRTPC_SEQ_RESET;
            seq_cnt_q <= 8'(RESET_CYCLES - 1);
          end else if (restart_req) begin
            state_q <= prtpc_pkg::PRTPC_SEQ_RESTART;
            seq_cnt_q <= 8'(RESTART_CYCLES - 1);
          end
        end
        prtpc_pkg::PRTPC_SEQ_RESET: begin
          if (seq_done) begin
            state_q <= prtpc_pkg::PRTPC_SEQ_IDLE;
          end else begin
            seq_cnt_q <= seq_cnt_q - 8'h01;
          end
        end
        prtpc_pkg::PRTPC_SEQ_RESTART: begin
          if (full_req) begin
            state_q <= prtpc_pkg::PRTPC_SEQ_RESET;
            seq_cnt_q <= 8'(RESET_CYCLES - 1);
          end else if (seq_done) begin
            state_q <= prtpc_pkg::PRTPC_SEQ_IDLE;
          end else begin
            seq_cnt_q <= seq_cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= prtpc_pkg::PRTPC_SEQ_IDLE;
          seq_cnt_q <= 8'h00;
        end
      endcase
    end
  end

  // reset control register; trigger bits mirror sequencer activity
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || full_busy) begin
      reset_ctrl_q <= `PRTPC_RST_RESET_CTRL;
    end else if (wr_reset_ctrl) begin
      reset_ctrl_q <= req.wdata & `PRTPC_RESET_CTRL_RW_MASK;
    end
  end

  // test-pattern register; survives a restart, defaults on full reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || full_busy) begin
      test_ctrl_q <= `PRTPC_RST_TEST_CTRL;
    end else if (wr_test_ctrl) begin
      test_ctrl_q <= req.wdata & `PRTPC_TEST_CTRL_RW_MASK;
    end
  end

  // read data one cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        `PRTPC_OFF_RESET_CTRL: rdata_q <= {full_busy, restart_busy, reset_ctrl_q[13:0]};
        `PRTPC_OFF_TEST_CTRL: rdata_q <= test_ctrl_q;
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign rdata_o = rdata_q;
  assign strap_default_o = strap_latch_q;
  assign core_reset_n_o = !full_busy;
  assign restart_o = restart_busy;

  prtpc_pattern_decode u_decode (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .test_ctrl_i(test_ctrl_q),
    .cfg_o(test_cfg_o)
  );

  // fast pattern engine: one followed by zero_count zeros
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      shift_q <= 5'h00;
      zcnt_q <= 5'h00;
    end else if (!test_cfg_o.ext_fast_active || restart_busy || full_busy) begin
      shift_q <= 5'h00;
      zcnt_q <= 5'h00;
    end else if (test_cfg_o.zero_count == `PRTPC_ZCNT_NONE) begin
      shift_q <= 5'h00;
      zcnt_q <= 5'h00;
    end else if (zcnt_q == 5'h00) begin
      shift_q <= {shift_q[3:0], 1'b1};
      zcnt_q <= test_cfg_o.zero_count;
    end else begin
      shift_q <= {shift_q[3:0], 1'b0};
      zcnt_q <= zcnt_q - 5'h01;
    end
  end

  assign fast_pattern_o = shift_q[0];
  assign fast_shift_o = shift_q;

  int unsigned gap_q;
  logic seen_one_q;
  // helper: cycles since last one bit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || shift_q[0]) begin
      gap_q <= 0;
    end else begin
      gap_q <= gap_q + 1;
    end
  end

  // helper: a one was seen since the pattern last started, so the gap is a full period
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !test_cfg_o.ext_fast_active || restart_busy || full_busy) begin
      seen_one_q <= 1'b0;
    end else if (shift_q[0]) begin
      seen_one_q <= 1'b1;
    end
  end

  a_reset_busy_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(full_busy) |-> full_busy[*8])
    else $error("full reset ended too early");
  a_reset_defaults: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    full_busy |=> test_ctrl_q == `PRTPC_RST_TEST_CTRL)
    else $error("test register not restored");
  a_strap_reload: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    full_busy |=> strap_latch_q == $past(strap_sync))
    else $error("strap values not reloaded");
  a_restart_keeps_regs: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    restart_busy && !wr_test_ctrl |=> $stable(test_ctrl_q))
    else $error("restart changed registers");
  a_restart_ends: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(restart_busy) && !wr_reset_ctrl |-> ##[1:40] !restart_busy)
    else $error("restart never completes");
  a_zero_count_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    test_cfg_o.zero_count == 5'h00 |=> shift_q == 5'h00)
    else $error("shift register not cleared");
  a_fast_needs_ten_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    test_cfg_o.ten_active |-> !test_cfg_o.ext_fast_active)
    else $error("fast pattern with ten-megabit enable");
  a_pair_all: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    test_ctrl_q[`PRTPC_BIT_ALL_PAIRS] && $stable(test_ctrl_q) |=> test_cfg_o.pair_enable == 4'hF)
    else $error("all pairs not driven");
  a_pair_single: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !test_ctrl_q[`PRTPC_BIT_ALL_PAIRS] |=> $countones(test_cfg_o.pair_enable) == 1)
    else $error("single pair select wrong");
  a_gap_length: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    shift_q[0] && test_cfg_o.ext_fast_active && $stable(test_cfg_o) && seen_one_q
      |-> gap_q == 32'(test_cfg_o.zero_count))
    else $error("wrong zero run length");
  a_busy_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    req.rd && req.addr == `PRTPC_OFF_RESET_CTRL && full_busy |=> rdata_o[15])
    else $error("reset bit not readable while busy");

  c_full_reset: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $fell(full_busy));
  c_restart: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $fell(restart_busy));
  c_fast_pattern: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(fast_pattern_o));
  c_ten_mode: cover property (@(posedge mclk_i) disable iff (!rst_n_i) test_cfg_o.ten_active);

endmodule

// ---- test/tb.sv ----
// self-checking bench for the reset and test-pattern control block
`include "prtpc_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RST_CYC = 16;
  localparam int RS_CYC = 8;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] strap_i = 16'hA5C3;
  logic [15:0] rdata_o;
  logic [15:0] strap_default_o;
  logic core_reset_n_o;
  logic restart_o;
  prtpc_pkg::prtpc_test_cfg_t test_cfg_o;
  logic fast_pattern_o;
  logic [4:0] fast_shift_o;
  int bad_count = 0;
  int samples_checked = 0;
  int rs_cnt = 0;
  int fr_cnt = 0;
  logic [15:0] rd_val;
  logic [2:0] lvl [4] = '{`PRTPC_LVL_P2, `PRTPC_LVL_M2, `PRTPC_LVL_P1, `PRTPC_LVL_M1};
  logic [15:0] straps [2] = '{16'hA5C3, 16'h3C5A};
  int zc [3] = '{1, 17, 31};

  prtpc_ctrl #(.RESET_CYCLES(RST_CYC), .RESTART_CYCLES(RS_CYC)) i_prtpc_ctrl (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .strap_i(strap_i),
    .strap_default_o(strap_default_o),
    .core_reset_n_o(core_reset_n_o),
    .restart_o(restart_o),
    .test_cfg_o(test_cfg_o),
    .fast_pattern_o(fast_pattern_o),
    .fast_shift_o(fast_shift_o)
  );

  // clock, 100 ns period
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  // cycles spent in restart and in full reset
  always @(negedge mclk_i) begin
    if (restart_o === 1'b1) rs_cnt++;
    if (core_reset_n_o === 1'b0) fr_cnt++;
  end

  // hang guard
  initial begin
    #3000000;
    bad_count++;
    conclude();
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string what, input logic [4:0] a, input logic [15:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    rd_val = rdata_o;
    chk(what, exp, rd_val);
  endtask

  // clear the test register first, then load the new pattern value
  task automatic cfg(input logic [15:0] d);
    reg_wr(5'h05, 16'h0000);
    reg_wr(5'h05, d);
    tick(3);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while ((core_reset_n_o !== 1'b1 || restart_o !== 1'b0) && n < 200) begin
      tick(1);
      n++;
    end
    if (n >= 200) begin
      bad_count++;
      conclude();
    end
  endtask

  // one followed by n zeros, checked over two periods
  task automatic fast_chk(input int n);
    int k;
    k = 0;
    while (fast_pattern_o !== 1'b1 && k < 64) begin
      tick(1);
      k++;
    end
    chk("fast one", 16'h0001, {15'h0000, fast_pattern_o});
    repeat (2) begin
      for (k = 0; k < n; k++) begin
        tick(1);
        chk("fast zero", 16'h0000, {15'h0000, fast_pattern_o});
      end
      tick(1);
      chk("fast one", 16'h0001, {15'h0000, fast_pattern_o});
    end
  endtask

  task automatic quiet_chk(input string what);
    repeat (8) begin
      tick(1);
      chk(what, 16'h0000, {11'h000, fast_shift_o, fast_pattern_o});
    end
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    tick(2);
    rchk("reset ctrl", 5'h1F, `PRTPC_RST_RESET_CTRL);
    tick(1);
    chk("read idle", 16'h0000, rdata_o);
    rchk("test ctrl", 5'h05, `PRTPC_RST_TEST_CTRL);
    rchk("unmapped", 5'h00, 16'h0000);
    chk("pair reset", 16'h000F, 16'(test_cfg_o.pair_enable));
    chk("pulse reset", 16'(lvl[1]), 16'(test_cfg_o.pulse_level));
    for (int i = 0; i < 4; i++) begin
      cfg(16'((i << 10) | (i << 5)));
      chk("pulse level", 16'(lvl[i]), 16'(test_cfg_o.pulse_level));
      chk("pair select", 16'(1 << i), 16'(test_cfg_o.pair_enable));
    end
    cfg(16'h00E0);
    chk("all pairs", 16'h000F, 16'(test_cfg_o.pair_enable));
    reg_wr(5'h05, 16'hFFFF);
    rchk("test mask", 5'h05, `PRTPC_TEST_CTRL_RW_MASK);
    for (int c = 0; c < 14; c++) begin
      cfg(16'(16'h0010 | c));
      chk("ten enable", 16'h0001, 16'(test_cfg_o.ten_active));
      chk("ten code", 16'(c), 16'(test_cfg_o.ten_code));
    end
    cfg(16'h0003);
    chk("ten off", 16'h0000, 16'(test_cfg_o.ten_active));
    reg_wr(5'h00, 16'h2000);
    rchk("speed reg", 5'h00, 16'h0000);
    foreach (zc[j]) begin
      cfg(16'(16'h0100 | ((zc[j] >> 4) << 9) | (zc[j] & 15)));
      chk("zero count", 16'(zc[j]), 16'(test_cfg_o.zero_count));
      chk("fast enable", 16'h0001, 16'(test_cfg_o.ext_fast_active));
      fast_chk(zc[j]);
    end
    cfg(16'h0100);
    quiet_chk("shift cleared");
    cfg(16'h0112);
    quiet_chk("ten gates fast");
    // soft restart keeps the registers
    cfg(16'h0123);
    rs_cnt = 0;
    reg_wr(5'h1F, 16'h4000);
    rchk("restart busy", 5'h1F, 16'h4000);
    wait_idle();
    chk("restart len", 16'(RS_CYC), 16'(rs_cnt));
    rchk("restart done", 5'h1F, 16'h0000);
    rchk("regs kept", 5'h05, 16'h0123);
    // full reset restores defaults and reloads straps
    for (int r = 0; r < 2; r++) begin
      strap_i <= straps[r];
      tick(6);
      fr_cnt = 0;
      reg_wr(5'h1F, 16'h8000);
      rchk("reset busy", 5'h1F, 16'h8000);
      reg_wr(5'h05, 16'h0111);
      wait_idle();
      chk("reset len", 16'(RST_CYC), 16'(fr_cnt));
      rchk("ctrl default", 5'h1F, `PRTPC_RST_RESET_CTRL);
      rchk("test default", 5'h05, `PRTPC_RST_TEST_CTRL);
      chk("strap reload", straps[r], strap_default_o);
    end
    conclude();
  end
endmodule
